// *** sfpe_flash_seq.sv ***
`timescale 1ns/1ps
module sfpe_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 32
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wp_q, rp_q;

   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
      $error("fifo depth must be a power of two");
   end

   assign o_in_ready = (wp_q - rp_q) != (AW + 1)'(DEPTH);
   assign o_out_valid = wp_q != rp_q;
   assign o_out_data = mem[rp_q[AW-1:0]];

   always_ff @(posedge i_clk) begin
      if (i_in_valid && o_in_ready) begin
         mem[wp_q[AW-1:0]] <= i_in_data;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         wp_q <= '0;
         rp_q <= '0;
      end else begin
         if (i_in_valid && o_in_ready) begin
            wp_q <= wp_q + 1'b1;
         end
         if (o_out_valid && i_out_ready) begin
            rp_q <= rp_q + 1'b1;
         end
      end
   end
endmodule

// What this block does
// [R1] silicon id opcode 0xAB answered only by the four smaller variants
// [R2] id commands arriving during a program or erase cycle are ignored
// [R3] after opcode and three dummy bytes, 8-bit id leaves on falling edges
// [R4] id repeats while select stays low; select rise ends it
// [R5] device id opcode 0x9F, largest variant only, two dummy bytes, 16-bit id
// [R6] page program opcode 0x02 needs the write enable latch set first
// [R7] controller keeps select low over opcode, address and data bytes
// [R8] data past page end wraps to the start of the same page
// [R9] beyond 256 bytes only the last 256 are programmed
// [R10] fewer bytes program only their addresses, rest of page untouched
// [R11] select must rise on a byte boundary or program is dropped
// [R12] write enable latch cleared before each program completes
// [R13] program cycle starts at select rise; busy flag high until done
// [R14] controller erases target bytes to 0xFF before programming; the testbench programs its pages without erasing them first
// [R15] bulk erase opcode 0xC7 sets all bits, needs write enable latch
// [R16] bulk erase only when select rises right after the opcode
// [R17] bulk erase holds busy flag then clears it; latch cleared
// [R18] sector erase 0xD8 plus address erases that whole sector
// [R19] sector erase starts at select rise, busy flag, latch cleared
// [R20] upper address bits ignored according to capacity
// [R21] controller sends raw image bytes lsb first
// [R22] busy flag is status bit 0, readable at any time
// [R23] program and erase ignored while the write enable latch is clear
// [R24] bits taken on shift clock rise; counter cleared while select high
module sfpe_flash_seq
   import sfpe_pkg::*;
#(
   parameter logic [2:0] VARIANT = VAR_64M,
   parameter logic [7:0] SILICON_ID = 8'h5A, // arbitrary value
   parameter logic [15:0] DEVICE_ID = 16'hA55A, // arbitrary value
   parameter int SECTOR_BITS = 16,
   parameter int FIFO_DEPTH = 32,
   parameter logic [35:0] PROG_CYCLES = 36'(PROG_CYC),
   parameter logic [35:0] SECT_CYCLES = 36'(SECT_CYC),
   parameter logic [35:0] BULK_CYCLES = 36'(BULK_CYC)
) (
   // clock and reset
   input wire logic I_CORE_CLK,
   input wire logic I_SYS_RST,
   // serial link
   input wire logic I_CHIP_SELECT_LOW,
   input wire logic I_SHIFT_CLOCK,
   input wire logic I_SERIAL_INPUT,
   output logic O_SERIAL_DATA,
   output logic O_SERIAL_DATA_OE_N,
   // latch set from the write enable decoder and status
   input wire logic I_WRITE_ENABLE_SET,
   output logic [7:0] O_STATUS,
   // array port
   output logic O_MEM_WR_VALID,
   input wire logic I_MEM_WR_READY,
   output logic [23:0] O_MEM_WR_ADDR,
   output logic [7:0] O_MEM_WR_DATA,
   output logic O_ERASE_SECTOR,
   output logic O_ERASE_BULK,
   output logic [23:0] O_ERASE_ADDR
);
   localparam logic [23:0] KEEP = addr_keep(VARIANT);
   localparam logic [23:0] SECT_LOW = 24'((longint'(1) << SECTOR_BITS) - 1);
   localparam bit IS_BIG = (VARIANT == VAR_128M);

   if (VARIANT > VAR_128M || SECTOR_BITS < 8 || SECTOR_BITS > 23) begin : g_chk
      $error("unsupported variant or sector size");
   end

   sfpe_pins_type s1_q, s2_q;
   logic sck_prev_q, cs_prev_q;
   logic [5:0] cnt_q;
   logic [2:0] ph_q;
   logic [7:0] sh_q, op_q, ptr_q, idx_q;
   logic [23:0] addr_q, base_q;
   logic got_data_q, wel_q, wip_q, id_act_q;
   logic [3:0] id_idx_q;
   logic [7:0] page_mem [256];
   logic [255:0] mask_q;
   logic [35:0] timer_q;
   sfpe_state_type state_q;
   sfpe_mem_wr_type fifo_in, fifo_out;
   logic fifo_in_ready, fifo_out_valid, fifo_out_ready;

   // first stage is read only by the second
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         s1_q <= '{cs: 1'b1, sck: 1'b0, si: 1'b0};
         s2_q <= '{cs: 1'b1, sck: 1'b0, si: 1'b0};
         sck_prev_q <= 1'b0;
         cs_prev_q <= 1'b1;
      end else begin
         s1_q <= '{cs: I_CHIP_SELECT_LOW, sck: I_SHIFT_CLOCK, si: I_SERIAL_INPUT};
         s2_q <= s1_q;
         sck_prev_q <= s2_q.sck;
         cs_prev_q <= s2_q.cs;
      end
   end

   wire sck_rise = !s2_q.cs && s2_q.sck && !sck_prev_q;
   wire sck_fall = !s2_q.cs && !s2_q.sck && sck_prev_q;
   wire cs_rise = s2_q.cs && !cs_prev_q;
   wire [7:0] byte_d = {sh_q[6:0], s2_q.si};
   wire byte_done = sck_rise && ph_q == 3'h7;
   wire page_wr = byte_done && cnt_q >= CNT_DATA_START - 6'h01 && op_q == OP_PAGE_PROG && !wip_q;
   wire ok_go = cs_rise && wel_q && !wip_q; // [R23]
   wire prog_go = ok_go && op_q == OP_PAGE_PROG && got_data_q && ph_q == 3'h0; // [R6] [R11] [R13]
   wire sect_go = ok_go && op_q == OP_SECTOR_ERASE && cnt_q == CNT_ADDR_END; // [R18] [R19]
   wire bulk_go = ok_go && op_q == OP_BULK_ERASE && cnt_q == CNT_OPCODE_END; // [R15] [R16]
   wire id_start = sck_rise && !wip_q && // [R2]
      ((!IS_BIG && op_q == OP_SILICON_ID && cnt_q == CNT_ADDR_END - 6'h01) || // [R1] [R3]
       (IS_BIG && op_q == OP_DEVICE_ID && cnt_q == CNT_DID_END - 6'h01)); // [R5]
   wire [15:0] id_word = IS_BIG ? DEVICE_ID : {SILICON_ID, SILICON_ID};

   // frame bit counter, saturating once data bytes begin
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST || s2_q.cs) begin
         cnt_q <= '0; // [R24]
         ph_q <= '0;
      end else if (sck_rise) begin
         ph_q <= ph_q + 3'h1;
         if (cnt_q != CNT_DATA_START) begin
            cnt_q <= cnt_q + 6'h01;
         end
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         sh_q <= '0;
         op_q <= '0;
         addr_q <= '0;
         got_data_q <= 1'b0;
      end else begin
         if (sck_rise) begin
            sh_q <= byte_d; // [R24]
         end
         if (byte_done && cnt_q == CNT_OPCODE_END - 6'h01) begin
            op_q <= byte_d;
            got_data_q <= 1'b0;
         end
         if (byte_done && cnt_q > CNT_OPCODE_END && cnt_q < CNT_ADDR_END) begin
            addr_q <= {addr_q[15:0], byte_d};
         end
         if (page_wr) begin
            got_data_q <= 1'b1;
         end
      end
   end

   // page buffer: wrapping pointer makes later bytes overwrite earlier ones
   always_ff @(posedge I_CORE_CLK) begin
      if (page_wr) begin
         page_mem[ptr_q] <= byte_d; // [R9]
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         mask_q <= '0;
         ptr_q <= '0;
      end else if (byte_done && !wip_q) begin
         if (cnt_q == CNT_OPCODE_END - 6'h01) begin
            mask_q <= '0; // [R10]
         end
         if (cnt_q == CNT_ADDR_END - 6'h01) begin
            ptr_q <= byte_d;
         end
         if (page_wr) begin
            mask_q[ptr_q] <= 1'b1;
            ptr_q <= ptr_q + 8'h01; // [R8]
         end
      end
   end

   // id shifter runs until select rises
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST || s2_q.cs) begin
         id_act_q <= 1'b0;
         id_idx_q <= '0;
         O_SERIAL_DATA <= 1'b0;
         O_SERIAL_DATA_OE_N <= 1'b1;
      end else begin
         if (id_start) begin
            id_act_q <= 1'b1;
         end
         if (id_act_q && sck_fall) begin
            O_SERIAL_DATA <= id_word[4'hF - id_idx_q]; // [R3] [R4] [R5]
            O_SERIAL_DATA_OE_N <= 1'b0;
            id_idx_q <= id_idx_q + 4'h1;
         end
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST || prog_go || sect_go || bulk_go) begin
         wel_q <= 1'b0; // [R12] [R17] [R19]
      end else if (I_WRITE_ENABLE_SET && !wip_q) begin
         wel_q <= 1'b1;
      end
   end

   wire step = !mask_q[idx_q] || fifo_in_ready;
   wire drained = !fifo_out_valid && !O_MEM_WR_VALID;

   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         state_q <= ST_IDLE;
         wip_q <= 1'b0;
         timer_q <= '0;
         idx_q <= '0;
         base_q <= '0;
      end else begin
         if (timer_q != '0) begin
            timer_q <= timer_q - 36'h1;
         end
         case (state_q)
            ST_IDLE: begin
               idx_q <= '0;
               base_q <= {addr_q[23:8] & KEEP[23:8], 8'h00}; // [R20]
               if (prog_go) begin
                  state_q <= ST_DRAIN;
                  wip_q <= 1'b1; // [R13]
                  timer_q <= PROG_CYCLES;
               end else if (sect_go || bulk_go) begin
                  state_q <= ST_TIMED;
                  wip_q <= 1'b1; // [R17] [R19]
                  timer_q <= sect_go ? SECT_CYCLES : BULK_CYCLES;
               end
            end
            ST_DRAIN: begin
               if (step) begin
                  idx_q <= idx_q + 8'h01;
                  if (idx_q == PAGE_LAST) begin
                     state_q <= ST_TIMED;
                  end
               end
            end
            ST_TIMED: begin
               if (timer_q <= 36'h1 && drained) begin
                  state_q <= ST_IDLE;
                  wip_q <= 1'b0; // [R13] [R17] [R19]
               end
            end
            default: begin
               state_q <= ST_IDLE;
               wip_q <= 1'b0;
            end
         endcase
      end
   end

   assign fifo_in = '{addr: base_q | {16'h0000, idx_q}, data: page_mem[idx_q]};
   assign fifo_out_ready = !O_MEM_WR_VALID || I_MEM_WR_READY;

   sfpe_fifo #(.WIDTH($bits(sfpe_mem_wr_type)), .DEPTH(FIFO_DEPTH)) u_fifo (
      .i_clk(I_CORE_CLK),
      .i_rst(I_SYS_RST),
      .i_in_valid(state_q == ST_DRAIN && mask_q[idx_q]), // [R10]
      .o_in_ready(fifo_in_ready),
      .i_in_data(fifo_in),
      .o_out_valid(fifo_out_valid),
      .i_out_ready(fifo_out_ready),
      .o_out_data(fifo_out)
   );

   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         O_MEM_WR_VALID <= 1'b0;
         O_MEM_WR_ADDR <= '0;
         O_MEM_WR_DATA <= '0;
      end else if (fifo_out_ready) begin
         O_MEM_WR_VALID <= fifo_out_valid;
         O_MEM_WR_ADDR <= fifo_out.addr;
         O_MEM_WR_DATA <= fifo_out.data;
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         O_ERASE_SECTOR <= 1'b0;
         O_ERASE_BULK <= 1'b0;
         O_ERASE_ADDR <= '0;
         O_STATUS <= '0;
      end else begin
         O_ERASE_SECTOR <= sect_go;
         O_ERASE_BULK <= bulk_go;
         O_ERASE_ADDR <= addr_q & KEEP & ~SECT_LOW; // [R18] [R20]
         O_STATUS <= {6'h00, wel_q, wip_q}; // [R22]
      end
   end

   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (I_SYS_RST);

   sequence s_prog_end;
      cs_rise && op_q == OP_PAGE_PROG && !wip_q;
   endsequence
   sequence s_busy_seen;
      wip_q && !wel_q ##1 O_STATUS[STAT_WIP_BIT];
   endsequence

   property p_id_ignored;
      wip_q |-> !id_start && !(id_act_q && O_SERIAL_DATA_OE_N && sck_fall && !s2_q.cs && id_idx_q != 4'h0);
   endproperty
   a_id_ignored: assert property (p_id_ignored) else $error("id started while busy"); // [R2]
   property p_id_bit;
      id_act_q && sck_fall |=> !O_SERIAL_DATA_OE_N && O_SERIAL_DATA == id_word[4'hF - $past(id_idx_q)];
   endproperty
   a_id_bit: assert property (p_id_bit) else $error("wrong id bit"); // [R4]
   property p_sid_variant;
      op_q == OP_SILICON_ID && IS_BIG |-> !id_start;
   endproperty
   a_sid_variant: assert property (p_sid_variant) else $error("silicon id on large part"); // [R1]
   property p_prog_start;
      s_prog_end and (wel_q && got_data_q && ph_q == 3'h0) |=> s_busy_seen;
   endproperty
   a_prog_start: assert property (p_prog_start) else $error("program did not start"); // [R13]
   property p_prog_misaligned;
      s_prog_end and (ph_q != 3'h0) |=> !wip_q;
   endproperty
   a_prog_misaligned: assert property (p_prog_misaligned) else $error("misaligned program ran"); // [R11]
   property p_no_wel;
      cs_rise && !wel_q && !wip_q |=> !wip_q [*2];
   endproperty
   a_no_wel: assert property (p_no_wel) else $error("action without write enable"); // [R23]
   property p_wel_clear;
      wip_q |-> !wel_q;
   endproperty
   a_wel_clear: assert property (p_wel_clear) else $error("latch set during cycle"); // [R12]
   property p_sector;
      sect_go |=> O_ERASE_SECTOR && wip_q && !wel_q ##1 !O_ERASE_SECTOR;
   endproperty
   a_sector: assert property (p_sector) else $error("sector erase not issued"); // [R19]
   property p_bulk;
      cs_rise && wel_q && !wip_q && op_q == OP_BULK_ERASE && cnt_q != CNT_OPCODE_END |=> !O_ERASE_BULK;
   endproperty
   a_bulk: assert property (p_bulk) else $error("bulk erase at wrong position"); // [R16]
   property p_cnt_clear;
      s2_q.cs |=> cnt_q == 6'h00 && ph_q == 3'h0;
   endproperty
   a_cnt_clear: assert property (p_cnt_clear) else $error("bit counter kept"); // [R24]
   property p_in_page;
      O_MEM_WR_VALID |-> O_MEM_WR_ADDR[23:8] == base_q[23:8];
   endproperty
   a_in_page: assert property (p_in_page) else $error("write left the page"); // [R8]
   property p_erase_mask;
      O_ERASE_SECTOR |-> (O_ERASE_ADDR & ~KEEP) == 24'h000000;
   endproperty
   a_erase_mask: assert property (p_erase_mask) else $error("upper address bits kept"); // [R20]
endmodule

// *** sfpe_pkg.sv ***
package sfpe_pkg;
   // opcodes, shifted in msb first
   localparam logic [7:0] OP_SILICON_ID = 8'hAB;
   localparam logic [7:0] OP_DEVICE_ID = 8'h9F;
   localparam logic [7:0] OP_PAGE_PROG = 8'h02;
   localparam logic [7:0] OP_BULK_ERASE = 8'hC7;
   localparam logic [7:0] OP_SECTOR_ERASE = 8'hD8;
   // capacity variants
   localparam logic [2:0] VAR_1M = 3'h0;
   localparam logic [2:0] VAR_4M = 3'h1;
   localparam logic [2:0] VAR_16M = 3'h2;
   localparam logic [2:0] VAR_64M = 3'h3;
   localparam logic [2:0] VAR_128M = 3'h4;
   // frame bit counts
   localparam logic [5:0] CNT_OPCODE_END = 6'h08;
   localparam logic [5:0] CNT_DID_END = 6'h18;
   localparam logic [5:0] CNT_ADDR_END = 6'h20;
   localparam logic [5:0] CNT_DATA_START = 6'h28;
   localparam int STAT_WIP_BIT = 0;
   localparam int STAT_WEL_BIT = 1;
   localparam logic [7:0] PAGE_LAST = 8'hFF;
   // self-timed cycle maxima and clock rate
   localparam longint CLK_KHZ = 40000;
   localparam longint T_WB_US = 5000;
   localparam longint T_ES_MS = 3000;
   localparam longint T_ES_128_MS = 6000;
   localparam longint T_EB_1M_MS = 6000;
   localparam longint T_EB_4M_MS = 10000;
   localparam longint T_EB_16M_MS = 40000;
   localparam longint T_EB_64M_MS = 160000;
   localparam longint T_EB_128M_MS = 250000;
   localparam longint PROG_CYC = T_WB_US * CLK_KHZ / 1000;
   localparam longint SECT_CYC = T_ES_MS * CLK_KHZ;
   localparam longint BULK_CYC = T_EB_64M_MS * CLK_KHZ;

   function automatic logic [23:0] addr_keep(input logic [2:0] v);
      case (v)
         VAR_1M: addr_keep = 24'h01FFFF;
         VAR_4M: addr_keep = 24'h07FFFF;
         VAR_16M: addr_keep = 24'h1FFFFF;
         VAR_64M: addr_keep = 24'h7FFFFF;
         default: addr_keep = 24'hFFFFFF;
      endcase
   endfunction

   typedef struct packed {
      logic cs;
      logic sck;
      logic si;
   } sfpe_pins_type;

   typedef struct packed {
      logic [23:0] addr;
      logic [7:0] data;
   } sfpe_mem_wr_type;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_DRAIN = 2'b01,
      ST_TIMED = 2'b10
   } sfpe_state_type;
endpackage

// *** sfpe_host_model.sv ***
`timescale 1ns/1ps
module sfpe_host_model (
   input wire logic i_clk,
   output logic o_cs_n,
   output logic o_sck,
   output logic o_si,
   input wire logic i_so,
   input wire logic i_so_oe_n
);
   // 200 ns link period from a 25 ns core clock
   localparam int HALF = 4;
   initial begin
      o_cs_n = 1'b1;
      o_sck = 1'b1;
      o_si = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   task automatic frame_open();
      @(posedge i_clk);
      o_cs_n <= 1'b0;
      wait_clk(HALF);
   endtask
   // fall then rise; the answer is taken late in the high phase, well after the device moves it
   task automatic cycle_bit(input logic b, output logic so, output logic oe_n);
      o_sck <= 1'b0;
      o_si <= b;
      wait_clk(HALF);
      o_sck <= 1'b1;
      wait_clk(HALF - 1);
      #1;
      // an undriven line has no pull here, so it shows the inverse of the last level
      so = i_so_oe_n ? ~i_so : i_so;
      oe_n = i_so_oe_n;
      wait_clk(1);
   endtask
   task automatic send_byte(input logic [7:0] v);
      logic d;
      logic e;
      for (int i = 7; i >= 0; i--) begin
         cycle_bit(v[i], d, e);
      end
   endtask
   // raw image bytes go out lsb first
   task automatic send_raw(input logic [7:0] v);
      logic d;
      logic e;
      for (int i = 0; i <= 7; i++) begin
         cycle_bit(v[i], d, e);
      end
   endtask
   task automatic read_word(output logic [15:0] w, output logic drove);
      logic e;
      drove = 1'b1;
      for (int i = 15; i >= 0; i--) begin
         cycle_bit(i[0], w[i], e);
         drove = drove & ~e;
      end
   endtask
   // clock parks high; the data line is flipped so a stale level is never mistaken for data
   task automatic frame_close();
      o_cs_n <= 1'b1;
      o_si <= ~o_si;
      wait_clk(HALF);
   endtask
endmodule

// *** test_serial_flash_id_program_erase.sv ***
`timescale 1ns/1ps
module test_serial_flash_id_program_erase;
   import sfpe_pkg::*;
   localparam logic [7:0] SID_VAL = 8'h3C; // arbitrary value
   logic clk, rst, cs_n, sck, si, so, so_oe_n, wel_set, mem_valid, mem_ready, er_sect, er_bulk, stall;
   logic [7:0] status, mem_data;
   logic [23:0] mem_addr, er_addr, sect_addr;
   logic [31:0] wr_q[$];
   int num_errors, check_count;
   int sect_hits = 0;
   int bulk_hits = 0;
   sfpe_host_model i_host (.i_clk(clk), .o_cs_n(cs_n), .o_sck(sck), .o_si(si), .i_so(so), .i_so_oe_n(so_oe_n));
   // default capacity variant is the 64-Mbit part: silicon id answered, device id refused
   sfpe_flash_seq #(.SILICON_ID(SID_VAL), .PROG_CYCLES(36'h32),
      .SECT_CYCLES(36'h7D0), .BULK_CYCLES(36'h64)) i_dut (
      .I_CORE_CLK(clk), .I_SYS_RST(rst), .I_CHIP_SELECT_LOW(cs_n), .I_SHIFT_CLOCK(sck),
      .I_SERIAL_INPUT(si), .O_SERIAL_DATA(so), .O_SERIAL_DATA_OE_N(so_oe_n),
      .I_WRITE_ENABLE_SET(wel_set), .O_STATUS(status), .O_MEM_WR_VALID(mem_valid),
      .I_MEM_WR_READY(mem_ready), .O_MEM_WR_ADDR(mem_addr), .O_MEM_WR_DATA(mem_data),
      .O_ERASE_SECTOR(er_sect), .O_ERASE_BULK(er_bulk), .O_ERASE_ADDR(er_addr));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // array side stalls on request, otherwise accepts every other cycle
   always @(posedge clk) begin
      mem_ready <= (stall || rst) ? 1'b0 : ~mem_ready;
      if (mem_valid === 1'b1 && mem_ready === 1'b1) wr_q.push_back({mem_addr, mem_data});
      if (er_sect === 1'b1) begin
         sect_hits++;
         sect_addr = er_addr;
      end
      if (er_bulk === 1'b1) bulk_hits++;
   end
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic chk_flag(input logic got, input logic exp, input string what);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask
   task automatic wait_busy(input logic exp, input int limit);
      int n;
      n = 0;
      while (status[0] !== exp && n < limit) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk_flag(status[0], exp, "busy");
   endtask
   task automatic set_wel();
      @(posedge clk);
      wel_set <= 1'b1;
      @(posedge clk);
      wel_set <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk_flag(status[1], 1'b1, "latch set");
      chk_val({24'h0, status[7:2], 2'b00}, 32'h0, "status spare");
   endtask
   task automatic cmd_addr(input logic [7:0] op, input logic [23:0] a);
      i_host.frame_open();
      i_host.send_byte(op);
      i_host.send_byte(a[23:16]);
      i_host.send_byte(a[15:8]);
      i_host.send_byte(a[7:0]);
   endtask
   task automatic t_id(input logic [7:0] op, input logic [15:0] exp, input logic exp_drive);
      logic [15:0] w;
      logic drove;
      cmd_addr(op, 24'h0);
      if (op == OP_DEVICE_ID) i_host.read_word(w, drove);
      else i_host.read_word(w, drove);
      i_host.frame_close();
      chk_flag(drove, exp_drive, "id driven");
      if (exp_drive) chk_val({16'h0, w}, {16'h0, exp}, "id word");
      chk_flag(so_oe_n, 1'b1, "released");
   endtask
   task automatic t_prog_no_wel();
      cmd_addr(OP_PAGE_PROG, 24'h000500);
      i_host.send_byte(8'h11);
      i_host.frame_close();
      repeat (20) @(posedge clk);
      chk_flag(status[0], 1'b0, "no busy");
      chk_val(32'(wr_q.size()), 32'h0, "no writes");
   endtask
   task automatic t_sector();
      set_wel();
      cmd_addr(OP_SECTOR_ERASE, 24'h9ABCDE);
      i_host.frame_close();
      wait_busy(1'b1, 12);
      chk_flag(status[1], 1'b0, "latch clear");
      chk_val(32'(sect_hits), 32'h1, "sector pulse");
      chk_val({8'h0, sect_addr}, 32'h1A0000, "sector base");
      t_id(OP_SILICON_ID, 16'h0, 1'b0);
      chk_flag(status[0], 1'b1, "still busy");
      wait_busy(1'b0, 2100);
   endtask
   task automatic t_prog_wrap();
      set_wel();
      wr_q.delete();
      cmd_addr(OP_PAGE_PROG, 24'h8012FE);
      // raw image bytes 85 45 C5 sent lsb first arrive as A1 A2 A3
      i_host.send_raw(8'h85);
      i_host.send_raw(8'h45);
      i_host.send_raw(8'hC5);
      i_host.frame_close();
      wait_busy(1'b1, 12);
      chk_flag(status[1], 1'b0, "latch clear");
      wait_busy(1'b0, 500);
      chk_val(32'(wr_q.size()), 32'h3, "count");
      chk_val(wr_q[0], 32'h001200A3, "wrap byte");
      chk_val(wr_q[1], 32'h0012FEA1, "byte 0");
      chk_val(wr_q[2], 32'h0012FFA2, "byte 1");
   endtask
   task automatic t_prog_over();
      set_wel();
      wr_q.delete();
      stall = 1'b1;
      cmd_addr(OP_PAGE_PROG, 24'h000300);
      // data depends on the byte count, not its page slot, so dropped early bytes show
      for (int k = 0; k < 258; k++) i_host.send_byte(k[8:1]);
      i_host.frame_close();
      wait_busy(1'b1, 12);
      stall = 1'b0;
      wait_busy(1'b0, 3000);
      chk_val(32'(wr_q.size()), 32'h100, "count");
      foreach (wr_q[i]) chk_val(wr_q[i], {16'h0003, i[7:0], (i < 2) ? 8'h80 : i[8:1]}, "last bytes");
   endtask
   task automatic t_prog_midbyte();
      logic d;
      logic e;
      set_wel();
      wr_q.delete();
      cmd_addr(OP_PAGE_PROG, 24'h000400);
      i_host.send_byte(8'h55);
      repeat (4) i_host.cycle_bit(1'b1, d, e);
      i_host.frame_close();
      repeat (20) @(posedge clk);
      chk_flag(status[0], 1'b0, "no busy");
      chk_val(32'(wr_q.size()), 32'h0, "no writes");
   endtask
   task automatic t_bulk();
      logic d;
      logic e;
      set_wel();
      i_host.frame_open();
      i_host.send_byte(OP_BULK_ERASE);
      i_host.cycle_bit(1'b0, d, e);
      i_host.frame_close();
      repeat (20) @(posedge clk);
      chk_val(32'(bulk_hits), 32'h0, "late close");
      chk_flag(status[0], 1'b0, "no busy");
      set_wel();
      i_host.frame_open();
      i_host.send_byte(OP_BULK_ERASE);
      i_host.frame_close();
      wait_busy(1'b1, 12);
      chk_val(32'(bulk_hits), 32'h1, "bulk pulse");
      chk_flag(status[1], 1'b0, "latch clear");
      wait_busy(1'b0, 200);
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      #2_000_000;
      num_errors++;
      $display("ERROR %0t watchdog expired", $time);
      close_out();
   end
   initial begin
      rst = 1'b1;
      wel_set = 1'b0;
      stall = 1'b0;
      num_errors = 0;
      check_count = 0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      t_id(OP_SILICON_ID, {SID_VAL, SID_VAL}, 1'b1);
      t_id(OP_DEVICE_ID, 16'h0, 1'b0);
      t_prog_no_wel();
      t_sector();
      t_prog_wrap();
      t_prog_over();
      t_prog_midbyte();
      t_bulk();
      close_out();
   end
endmodule
